// >>> src/ldbc_pkg.sv
package ldbc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WINDOW_BLEED = 8'h27;
  localparam logic [7:0] ADDR_DIVBUF_COUNT = 8'h28;
  localparam logic [7:0] RESET_WINDOW_BLEED = 8'hc5;
  localparam logic [7:0] RESET_DIVBUF_COUNT = 8'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DELAY_HI      = 7;
  localparam int DELAY_LO      = 6;
  localparam int PRECISION_BIT = 5;
  localparam int GATED_BIT     = 4;
  localparam int BLEED_BIT     = 3;
  localparam int REG_OFF_BIT   = 2;
  localparam int SHADOW_BIT    = 7;
  localparam int COUNT_HI      = 2;
  localparam int COUNT_LO      = 1;
  localparam int LOSS_BIT      = 0;
  localparam logic [7:0] DIVBUF_WRITE_MASK = 8'h87;

  // ----------------------------------------------------------------
  // Window timing in picoseconds, and at 100 MHz in clock cycles
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS = 10000;
  localparam int WIN_DELAY0_PS   = 5000;
  localparam int WIN_DELAY1_PS   = 6000;
  localparam int WIN_DELAY2_PS   = 8000;
  localparam int WIN_DELAY3_PS   = 12000;
  localparam int WIN_PRECISE_PS  = 2400;
  // Round down: an error of a whole cycle must fit inside the window
  function automatic logic [3:0] ldbc_cycles(input int ps);
    int c;
    c = ps / CLOCK_PERIOD_PS;
    return c[3:0];
  endfunction : ldbc_cycles

  // ----------------------------------------------------------------
  // Qualification counts
  // ----------------------------------------------------------------
  localparam int QUALIFY0 = 1024;
  localparam int QUALIFY1 = 2048;
  localparam int QUALIFY2 = 4096;
  localparam int QUALIFY3 = 8192;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } ldbc_req_t;

  typedef enum logic [1:0] {
    LDBC_IDLE   = 2'b00,
    LDBC_QUAL   = 2'b01,
    LDBC_LOCKED = 2'b10
  } ldbc_state_t;

endpackage : ldbc_pkg

// >>> src/ldbc_lock_detect_bleed_config.sv
module ldbc_lock_detect_bleed_config
  import ldbc_pkg::*;
#(
  parameter int DIV_WIDTH = 16,
  parameter int LOSS_LIMIT = 64
)(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire ldbc_req_t            req,
  input  wire logic                 req_valid,
  output logic [7:0]                rd_data,
  input  wire logic                 pfd_cycle,
  input  wire logic [3:0]           pfd_error_cycles,
  input  wire logic                 ref_present,
  input  wire logic                 output_gate_on_lock,
  input  wire logic                 rf_out_enable,
  input  wire logic [DIV_WIDTH-1:0] div_word_in,
  input  wire logic                 div_word_write,
  input  wire logic                 div_update,
  output logic [DIV_WIDTH-1:0]      div_word,
  output logic                      lock_detect,
  output logic                      bleed_on,
  output logic                      regulator_enable,
  output logic                      rf_out_on,
  output logic [3:0]                window_cycles
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] window_bleed_q;
  logic [7:0] divbuf_count_q;
  logic [7:0] rd_data_q;
  wire        wr_window = req_valid && req.write && (req.addr == ADDR_WINDOW_BLEED);
  wire        wr_divbuf = req_valid && req.write && (req.addr == ADDR_DIVBUF_COUNT);
  wire [7:0]  rd_mux = (req.addr == ADDR_WINDOW_BLEED) ? window_bleed_q :
                       (req.addr == ADDR_DIVBUF_COUNT) ? divbuf_count_q : 8'h00;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      window_bleed_q <= RESET_WINDOW_BLEED;
      divbuf_count_q <= RESET_DIVBUF_COUNT;
      rd_data_q      <= 8'h00;
    end
    else
    begin
      if (wr_window)
      begin
        window_bleed_q <= req.data;
      end
      if (wr_divbuf)
      begin
        divbuf_count_q <= req.data & DIVBUF_WRITE_MASK;
      end
      if (req_valid && !req.write)
      begin
        rd_data_q <= rd_mux;
      end
    end
  end
  assign rd_data = rd_data_q;

  // ----------------------------------------------------------------
  // Window selection
  // ----------------------------------------------------------------
  wire [1:0] delay_sel  = window_bleed_q[DELAY_HI:DELAY_LO];
  wire       precise    = window_bleed_q[PRECISION_BIT];
  wire [3:0] delay_cyc  = (delay_sel == 2'h0) ? ldbc_cycles(WIN_DELAY0_PS) :
                          (delay_sel == 2'h1) ? ldbc_cycles(WIN_DELAY1_PS) :
                          (delay_sel == 2'h2) ? ldbc_cycles(WIN_DELAY2_PS) :
                                                ldbc_cycles(WIN_DELAY3_PS);
  // Precision narrows the window regardless of the delay setting
  wire [3:0] win_cyc_d  = precise ? ldbc_cycles(WIN_PRECISE_PS) : delay_cyc;
  // Under 10 ns only an error-free comparison counts as in window
  wire       in_window  = pfd_error_cycles <= win_cyc_d;

  // ----------------------------------------------------------------
  // Lock qualification
  // ----------------------------------------------------------------
  wire [1:0]  count_sel = divbuf_count_q[COUNT_HI:COUNT_LO];
  wire [13:0] qual_target = (count_sel == 2'h0) ? 14'(QUALIFY0) :
                            (count_sel == 2'h1) ? 14'(QUALIFY1) :
                            (count_sel == 2'h2) ? 14'(QUALIFY2) :
                                                  14'(QUALIFY3);
  wire        loss_en   = divbuf_count_q[LOSS_BIT];

  ldbc_state_t state_q;
  ldbc_state_t state_d;
  logic [13:0] qual_q;
  logic [13:0] qual_d;
  logic [6:0]  ref_gone_q;
  // Reference absence judged by missing activity for a fixed stretch
  wire         ref_lost = (ref_gone_q >= 7'(LOSS_LIMIT)) && !ref_present;
  wire         drop_lock = loss_en && ref_lost;

  always_comb
  begin
    state_d = state_q;
    qual_d  = qual_q;
    case (state_q)
      LDBC_IDLE:
      begin
        qual_d  = 14'h0000;
        state_d = LDBC_QUAL;
      end
      LDBC_QUAL:
      begin
        if (pfd_cycle)
        begin
          if (!in_window)
          begin
            qual_d = 14'h0000;
          end
          else if (qual_q + 14'h0001 >= qual_target)
          begin
            state_d = LDBC_LOCKED;
          end
          else
          begin
            qual_d = qual_q + 14'h0001;
          end
        end
      end
      LDBC_LOCKED:
      begin
        if (pfd_cycle && !in_window)
        begin
          qual_d  = 14'h0000;
          state_d = LDBC_QUAL;
        end
        else if (drop_lock)
        begin
          qual_d  = 14'h0000;
          state_d = LDBC_QUAL;
        end
      end
      default:
      begin
        state_d = LDBC_IDLE;
        qual_d  = 14'h0000;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= LDBC_IDLE;
      qual_q     <= 14'h0000;
      ref_gone_q <= 7'h00;
    end
    else
    begin
      state_q <= state_d;
      qual_q  <= qual_d;
      if (ref_present)
      begin
        ref_gone_q <= 7'h00;
      end
      else if (ref_gone_q != 7'h7f)
      begin
        ref_gone_q <= ref_gone_q + 7'h01;
      end
    end
  end

  wire lock_d = (state_d == LDBC_LOCKED);

  // ----------------------------------------------------------------
  // Bleed, regulator, output gate, divider shadow
  // ----------------------------------------------------------------
  wire bleed_d = window_bleed_q[BLEED_BIT] &&
                 (!window_bleed_q[GATED_BIT] || lock_d);
  wire reg_en_d = !window_bleed_q[REG_OFF_BIT];
  // Gating needs lock; software keeps the detector running to use it
  wire rf_d = rf_out_enable && (!output_gate_on_lock || lock_d);
  wire shadow = divbuf_count_q[SHADOW_BIT];

  logic [DIV_WIDTH-1:0] div_pend_q;
  logic [DIV_WIDTH-1:0] div_word_q;
  logic                 lock_q;
  logic                 bleed_q;
  logic                 reg_en_q;
  logic                 rf_q;
  logic [3:0]           win_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_pend_q <= '0;
      div_word_q <= '0;
      lock_q     <= 1'b0;
      bleed_q    <= 1'b0;
      reg_en_q   <= 1'b0;
      rf_q       <= 1'b0;
      win_q      <= 4'h0;
    end
    else
    begin
      if (div_word_write)
      begin
        div_pend_q <= div_word_in;
      end
      if (div_word_write && !shadow)
      begin
        div_word_q <= div_word_in;
      end
      else if (shadow && div_update)
      begin
        div_word_q <= div_pend_q;
      end
      lock_q   <= lock_d;
      bleed_q  <= bleed_d;
      reg_en_q <= reg_en_d;
      rf_q     <= rf_d;
      win_q    <= win_cyc_d;
    end
  end

  assign div_word         = div_word_q;
  assign lock_detect      = lock_q;
  assign bleed_on         = bleed_q;
  assign regulator_enable = reg_en_q;
  assign rf_out_on        = rf_q;
  assign window_cycles    = win_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_window_reset_value: assert property (@(posedge clock) $fell(rst) |->
    window_bleed_q == 8'hc5) else $error("window register reset wrong");
  chk_divbuf_reset_value: assert property (@(posedge clock) $fell(rst) |->
    divbuf_count_q == 8'h03) else $error("divider register reset wrong");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    divbuf_count_q[6:3] == 4'h0) else $error("reserved bits not zero");
  chk_window_width: assert property (@(posedge clock) disable iff (rst)
    (!precise && delay_sel == 2'h3) |=> win_q == 4'h1) else $error("window wrong");
  chk_precise_width: assert property (@(posedge clock) disable iff (rst)
    precise |=> win_q == 4'h0) else $error("precise window wrong");
  chk_gated_bleed: assert property (@(posedge clock) disable iff (rst)
    bleed_q && $past(window_bleed_q[GATED_BIT]) |-> lock_q) else $error("gated bleed");
  chk_bleed_off: assert property (@(posedge clock) disable iff (rst)
    !window_bleed_q[BLEED_BIT] |=> !bleed_q) else $error("bleed on while disabled");
  chk_regulator_bit: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> reg_en_q == !$past(window_bleed_q[REG_OFF_BIT])) else $error("regulator");
  chk_out_window_unlock: assert property (@(posedge clock) disable iff (rst)
    pfd_cycle && !in_window |=> !lock_q && qual_q == 14'h0000) else $error("no restart");
  chk_loss_unlock: assert property (@(posedge clock) disable iff (rst)
    drop_lock |=> !lock_q) else $error("reference loss kept lock");
  chk_output_gate: assert property (@(posedge clock) disable iff (rst)
    rf_q && $past(output_gate_on_lock) |-> lock_q) else $error("output not gated");
  chk_direct_word: assert property (@(posedge clock) disable iff (rst)
    div_word_write && !shadow |=> div_word_q == $past(div_word_in)) else $error("divider");

  // ----------------------------------------------------------------
  // Window, gating, reset, counting, masking and shadow checks
  // ----------------------------------------------------------------
  chk_short_window: assert property (@(posedge clock) disable iff (rst)
    (!precise && delay_sel != 2'h3) |=> win_q == 4'h0)
    else $error("short window wrong");
  chk_gate_holds_bleed: assert property (@(posedge clock) disable iff (rst)
    window_bleed_q[GATED_BIT] && !lock_d |=> !bleed_q)
    else $error("bleed on without lock");
  chk_reset_outputs: assert property (@(posedge clock) $fell(rst) |->
    !lock_q && !bleed_q && !reg_en_q)
    else $error("outputs not quiet after reset");
  chk_divbuf_mask: assert property (@(posedge clock) disable iff (rst)
    wr_divbuf |=> divbuf_count_q == ($past(req.data) & 8'h87))
    else $error("divider register mask wrong");
  chk_reserved_read: assert property (@(posedge clock) disable iff (rst)
    req_valid && !req.write && req.addr == ADDR_DIVBUF_COUNT |=> rd_data_q[6:3] == 4'h0)
    else $error("reserved bits read back");
  chk_lock_count: assert property (@(posedge clock) disable iff (rst)
    $rose(lock_q) |-> qual_q + 14'h0001 >= qual_target)
    else $error("lock before count reached");
  chk_no_early_lock: assert property (@(posedge clock) disable iff (rst)
    state_q != LDBC_LOCKED && qual_q + 14'h0001 < qual_target |=> !lock_q)
    else $error("lock came early");
  chk_loss_off_keeps: assert property (@(posedge clock) disable iff (rst)
    state_q == LDBC_LOCKED && !loss_en && !(pfd_cycle && !in_window) |=> lock_q)
    else $error("lock lost with loss unlock off");
  chk_shadow_hold: assert property (@(posedge clock) disable iff (rst)
    shadow && !div_update |=> div_word_q == $past(div_word_q))
    else $error("shadowed divider word moved");
  chk_shadow_update: assert property (@(posedge clock) disable iff (rst)
    shadow && div_update |=> div_word_q == $past(div_pend_q))
    else $error("buffered update missed");

endmodule : ldbc_lock_detect_bleed_config

// >>> testbench/lock_detect_bleed_config_tb_top.sv
`define CHK(nm, ex, sn) \
  begin \
    checked++; \
    if ((sn) !== (ex)) \
    begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", nm, ex, sn); \
    end \
  end

module lock_detect_bleed_config_tb_top
  import ldbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int LOSS = 8;
  logic        clock;
  logic        rst;
  ldbc_req_t   req;
  logic        req_valid;
  logic [7:0]  rd_data;
  logic        pfd_cycle;
  logic [3:0]  pfd_error_cycles;
  logic        ref_present;
  logic        output_gate_on_lock;
  logic        rf_out_enable;
  logic [15:0] div_word_in;
  logic        div_word_write;
  logic        div_update;
  logic [15:0] div_word;
  logic        lock_detect;
  logic        bleed_on;
  logic        regulator_enable;
  logic        rf_out_on;
  logic [3:0]  window_cycles;
  int          fails;
  int          checked;
  logic [7:0]  v;

  ldbc_lock_detect_bleed_config #(.DIV_WIDTH(16), .LOSS_LIMIT(LOSS)) DUT (
    .clock(clock), .rst(rst), .req(req), .req_valid(req_valid), .rd_data(rd_data),
    .pfd_cycle(pfd_cycle), .pfd_error_cycles(pfd_error_cycles),
    .ref_present(ref_present), .output_gate_on_lock(output_gate_on_lock),
    .rf_out_enable(rf_out_enable), .div_word_in(div_word_in),
    .div_word_write(div_word_write), .div_update(div_update), .div_word(div_word),
    .lock_detect(lock_detect), .bleed_on(bleed_on), .regulator_enable(regulator_enable),
    .rf_out_on(rf_out_on), .window_cycles(window_cycles)
  );

  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req       <= '{write: 1'b1, addr: a, data: d};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req       <= '{write: 1'b0, addr: a, data: 8'h00};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
    #1;
    v = rd_data;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  // Back to back comparisons, one per edge
  task automatic pfd(input int n, input logic [3:0] e);
    repeat (n)
    begin
      @(posedge clock);
      pfd_cycle        <= 1'b1;
      pfd_error_cycles <= e;
    end
    @(posedge clock);
    pfd_cycle <= 1'b0;
    settle(3);
  endtask : pfd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(8'h27);
    `CHK("window_bleed", 8'hc5, v)
    rd(8'h28);
    `CHK("divbuf_count", 8'h03, v)
    `CHK("regulator_enable", 1'b0, regulator_enable)
    `CHK("bleed_on", 1'b0, bleed_on)
    wr(8'h28, 8'hff);
    rd(8'h28);
    `CHK("divbuf_count", 8'h87, v)
    wr(8'h27, 8'h08);
    settle(2);
    `CHK("bleed_on", 1'b1, bleed_on)
    `CHK("regulator_enable", 1'b1, regulator_enable)
    wr(8'h30, 8'hff);
    rd(8'h30);
    `CHK("unmapped", 8'h00, v)
    rd(8'h27);
    `CHK("window_bleed", 8'h08, v)
    $display("test regs done");
  endtask : t_regs

  // Only the 12 ns window holds a whole 10 ns step
  task automatic t_window;
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h27, {i[1:0], i[2], 5'h05});
      settle(2);
      `CHK("window_cycles", (i == 3) ? 4'h1 : 4'h0, window_cycles)
    end
    $display("test window done");
  endtask : t_window

  task automatic t_lock;
    wr(8'h28, 8'h00);
    wr(8'h27, 8'h19);
    output_gate_on_lock <= 1'b1;
    pfd(1, 4'h2);
    pfd(1023, 4'h0);
    `CHK("lock_detect", 1'b0, lock_detect)
    `CHK("bleed_on", 1'b0, bleed_on)
    `CHK("rf_out_on", 1'b0, rf_out_on)
    pfd(1, 4'h0);
    `CHK("lock_detect", 1'b1, lock_detect)
    `CHK("bleed_on", 1'b1, bleed_on)
    `CHK("rf_out_on", 1'b1, rf_out_on)
    @(posedge clock);
    ref_present <= 1'b0;
    settle(2 * LOSS);
    `CHK("lock_detect", 1'b1, lock_detect)
    @(posedge clock);
    ref_present <= 1'b1;
    // A whole-cycle error falls outside the 5 ns window
    pfd(1, 4'h1);
    `CHK("lock_detect", 1'b0, lock_detect)
    `CHK("bleed_on", 1'b0, bleed_on)
    pfd(1023, 4'h0);
    `CHK("lock_detect", 1'b0, lock_detect)
    pfd(1, 4'h0);
    `CHK("lock_detect", 1'b1, lock_detect)
    // The 12 ns window tolerates that same error
    wr(8'h27, 8'hd9);
    pfd(1, 4'h1);
    `CHK("lock_detect", 1'b1, lock_detect)
    // Turning the loss unlock on, as recommended
    wr(8'h28, 8'h01);
    ref_present <= 1'b0;
    settle(LOSS + 4);
    `CHK("lock_detect", 1'b0, lock_detect)
    `CHK("rf_out_on", 1'b0, rf_out_on)
    @(posedge clock);
    ref_present <= 1'b1;
    $display("test lock done");
  endtask : t_lock

  task automatic t_shadow;
    wr(8'h28, 8'h03);
    div_word_in    <= 16'h00a5;
    div_word_write <= 1'b1;
    @(posedge clock);
    div_word_write <= 1'b0;
    settle(2);
    `CHK("div_word", 16'h00a5, div_word)
    wr(8'h28, 8'h83);
    div_word_in    <= 16'h1234;
    div_word_write <= 1'b1;
    @(posedge clock);
    div_word_write <= 1'b0;
    settle(3);
    `CHK("div_word", 16'h00a5, div_word)
    @(posedge clock);
    div_update <= 1'b1;
    @(posedge clock);
    div_update <= 1'b0;
    settle(2);
    `CHK("div_word", 16'h1234, div_word)
    $display("test shadow done");
  endtask : t_shadow

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    req = '0;
    req_valid = 1'b0;
    pfd_cycle = 1'b0;
    pfd_error_cycles = 4'h0;
    ref_present = 1'b1;
    output_gate_on_lock = 1'b0;
    rf_out_enable = 1'b1;
    div_word_in = 16'h0000;
    div_word_write = 1'b0;
    div_update = 1'b0;
    fails = 0;
    checked = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_window();
    t_lock();
    t_shadow();
    results();
  end

  // Whole run is about 2200 cycles; this allows ample margin
  initial
  begin
    #200us;
    fails++;
    results();
  end

endmodule : lock_detect_bleed_config_tb_top
